// ### src/ghf_gantry_home.v
// Behaviour
// RULE1 - Primary code 41..44 links the axis as slave to master axis 1..4.
// RULE2 - Enabling a master enables its slave; master motion commands go to the slave.
// RULE3 - Each axis closes its own loop on its own encoder and parameters.
// RULE4 - Master and slave search markers separately so home offsets fix orthogonality.
// RULE5 - Homing starts by moving both axes linked toward home until a limit.
// RULE6 - Limit is debounced linked, then optional limit-to-marker move, still linked.
// RULE7 - Unlinked, an axis finding its marker clears position and keeps moving.
// RULE8 - Both markers found: decelerate, dwell one second, expose marker distances.
// RULE9 - After dwell each axis moves unlinked by home offset minus marker distance.
// RULE10 - After offset moves, zero both positions, relink and flag home done.
// RULE11 - An abort during the post-marker dwell ends the home cycle.
// RULE12 - Operator gives equal home parameters and never commands a slave directly.
// RULE13 - Self-naming slave code is invalid; slave feeds from its own encoder.
// RULE14 - Secondary code: 0 open, 1-8 encoder, 9-16 resolver, 17-24 laser.
// RULE15 - Secondary feedback defaults to encoder channel equal to axis number.
// RULE16 - Laser codes 17-20 are x512 resolution, 21-24 are x4 resolution.
// RULE17 - Primary resolver code 0..5 selects resolution; default code is 3.
// RULE18 - Secondary resolver code uses the same resolution encoding.
// RULE19 - External resolver hardware is set to the selected resolution.
// RULE20 - Codes 37..40 make a slave that follows master home search and offsets.
// RULE21 - Limit debounce time is configurable and must elapse before acceptance.
`default_nettype none
`include "ghf_regs.vh"

module ghf_gantry_home #(
  parameter NAX       = 4,
  parameter PW        = 32,
  parameter DWELL_CYC = `GHF_DWELL_CYC
) (
  // Clock and reset
  input  wire              clk,
  input  wire              reset,
  // Register port
  input  wire [3:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata_ff,
  // Host motion requests per axis
  input  wire [NAX-1:0]    axis_enable_req,
  input  wire [NAX-1:0]    move_cmd_req,
  input  wire              abort_key,
  // Axis plant signals
  input  wire [NAX-1:0]    limit_hit,
  input  wire [NAX-1:0]    marker_hit,
  input  wire [NAX-1:0]    move_done,
  input  wire [NAX*PW-1:0] axis_position,
  // Axis commands
  output wire [NAX-1:0]    axis_enable,
  output wire [NAX-1:0]    move_cmd,
  output reg  [NAX-1:0]    home_jog_ff,
  output reg  [NAX-1:0]    pos_clear_ff,
  output reg  [NAX-1:0]    offset_move_ff,
  output reg  [NAX*PW-1:0] offset_dist_ff,
  output reg               l2m_move_ff,
  output reg               linked_ff,
  output reg               home_done_ff,
  output reg  [NAX*2-1:0]  loop_enc_sel_ff,
  output reg  [NAX*5-1:0]  pri_res_bits_ff,
  output reg  [NAX*5-1:0]  sec_res_bits_ff
);

  // ===================================================================
  // States
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_SEEK  = 4'h1;
  localparam [3:0] ST_DEB   = 4'h2;
  localparam [3:0] ST_L2M   = 4'h3;
  localparam [3:0] ST_MARK  = 4'h4;
  localparam [3:0] ST_DWELL = 4'h5;
  localparam [3:0] ST_OFS   = 4'h6;
  localparam [3:0] ST_ZERO  = 4'h7;

  // ===================================================================
  // Configuration registers
  reg [NAX*6-1:0]  pfb_ff;
  reg [NAX*5-1:0]  sfb_ff;
  reg [NAX*3-1:0]  pres_ff;
  reg [NAX*3-1:0]  sres_ff;
  reg [NAX*PW-1:0] ofs_ff;
  reg [23:0]       deb_lim_ff;
  reg              l2m_en_ff;

  reg [3:0]        st_ff;
  reg [NAX*PW-1:0] mdist_ff;
  reg [NAX-1:0]    mfound_ff;
  reg [NAX-1:0]    odone_ff;
  reg [31:0]       cnt_ff;
  reg              start_ff;

  wire [NAX-1:0]   sep;
  wire [NAX-1:0]   fol;
  wire [NAX*2-1:0] mst;
  wire [NAX*2-1:0] styp;
  wire [NAX-1:0]   lfine;
  wire [NAX*5-1:0] pbits;
  wire [NAX*5-1:0] sbits;
  wire [NAX-1:0]   is_slave = sep | fol;

  function [2:0] clip_res;
    input [2:0] v;
    begin
      clip_res = (v > `GHF_RES_CODE_MAX) ? `GHF_RES_CODE_RST : v;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NAX; g = g + 1)
    begin : g_ax
      ghf_axis_cfg #(.AXIS(g[1:0])) u_pri (
        .pfb_code     (pfb_ff[g*6 +: 6]),
        .sfb_code     (sfb_ff[g*5 +: 5]),
        .res_code     (pres_ff[g*3 +: 3]),
        .slave_sep    (sep[g]),
        .slave_follow (fol[g]),
        .master_idx   (mst[g*2 +: 2]),
        .sfb_type     (styp[g*2 +: 2]),
        .laser_fine   (lfine[g]),
        .res_bits     (pbits[g*5 +: 5])
      );
      ghf_axis_cfg #(.AXIS(g[1:0])) u_sec (
        .pfb_code     (6'h00),
        .sfb_code     (5'h00),
        .res_code     (sres_ff[g*3 +: 3]),
        .slave_sep    (),
        .slave_follow (),
        .master_idx   (),
        .sfb_type     (),
        .laser_fine   (),
        .res_bits     (sbits[g*5 +: 5])
      );
      // A slave follows its master's enable and motion commands.
      assign axis_enable[g] = is_slave[g] ? axis_enable_req[mst[g*2 +: 2]]
                                          : axis_enable_req[g];       // see RULE2
      // Direct motion to a slave is ignored; it only mirrors its master.
      assign move_cmd[g]    = is_slave[g] ? move_cmd_req[mst[g*2 +: 2]]
                                          : move_cmd_req[g];          // see RULE2 see RULE12
    end
  endgenerate

  // ===================================================================
  // Register writes
  integer i;
  always @(posedge clk)
  begin
    start_ff <= 1'b0;
    if (reset)
    begin
      for (i = 0; i < NAX; i = i + 1)
      begin
        pfb_ff[i*6 +: 6]  <= 6'h00;
        sfb_ff[i*5 +: 5]  <= i[4:0] + 5'h01;                        // see RULE15
        pres_ff[i*3 +: 3] <= `GHF_RES_CODE_RST;                     // see RULE17
        sres_ff[i*3 +: 3] <= `GHF_RES_CODE_RST;                     // see RULE18
      end
      ofs_ff     <= {NAX*PW{1'b0}};
      deb_lim_ff <= `GHF_DEBOUNCE_RST;
      l2m_en_ff  <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `GHF_REG_CTRL:
        begin
          start_ff  <= reg_wdata[`GHF_CTRL_START_BIT];
          l2m_en_ff <= reg_wdata[`GHF_CTRL_L2M_BIT];
        end
        `GHF_REG_PFB_CODE: pfb_ff <= reg_wdata[NAX*6-1:0];
        `GHF_REG_SFB_CODE: sfb_ff <= reg_wdata[NAX*5-1:0];
        `GHF_REG_RES_CODE:
        begin
          for (i = 0; i < NAX; i = i + 1)
          begin
            pres_ff[i*3 +: 3] <= clip_res(reg_wdata[i*3 +: 3]);
            sres_ff[i*3 +: 3] <= clip_res(reg_wdata[16 + i*3 +: 3]);
          end
        end
        `GHF_REG_DEBOUNCE: deb_lim_ff <= reg_wdata[23:0];          // see RULE21
        default:
        begin
          if (reg_addr >= `GHF_REG_HOME_OFS0 && reg_addr < `GHF_REG_MARK_DIST0)
            ofs_ff[(reg_addr - `GHF_REG_HOME_OFS0) * PW +: PW] <= reg_wdata[PW-1:0];
        end
      endcase
    end
  end

  wire sw_abort = reg_wr && (reg_addr == `GHF_REG_CTRL) && reg_wdata[`GHF_CTRL_ABORT_BIT];

  // ===================================================================
  // Feedback routing: each axis loops on its own encoder channel.
  always @(posedge clk)
  begin
    for (i = 0; i < NAX; i = i + 1)
    begin
      loop_enc_sel_ff[i*2 +: 2] <= i[1:0];                          // see RULE3 see RULE13
      pri_res_bits_ff[i*5 +: 5] <= pbits[i*5 +: 5];                 // see RULE19
      sec_res_bits_ff[i*5 +: 5] <= sbits[i*5 +: 5];
    end
  end

  // ===================================================================
  // Home sequencer for all linked pairs at once.
  wire any_limit  = |limit_hit;
  wire all_marked = &mfound_ff;
  wire all_done   = &odone_ff;

  always @(posedge clk)
  begin
    pos_clear_ff   <= {NAX{1'b0}};
    offset_move_ff <= {NAX{1'b0}};
    l2m_move_ff    <= 1'b0;
    if (reset)
    begin
      st_ff          <= ST_IDLE;
      cnt_ff         <= 32'h00000000;
      mfound_ff      <= {NAX{1'b0}};
      odone_ff       <= {NAX{1'b0}};
      mdist_ff       <= {NAX*PW{1'b0}};
      offset_dist_ff <= {NAX*PW{1'b0}};
      home_jog_ff    <= {NAX{1'b0}};
      linked_ff      <= 1'b1;
      home_done_ff   <= 1'b0;
    end
    else
    begin
      case (st_ff)
        ST_IDLE:
        begin
          if (start_ff)
          begin
            home_done_ff <= 1'b0;
            linked_ff    <= 1'b1;
            home_jog_ff  <= {NAX{1'b1}};                            // see RULE5
            st_ff        <= ST_SEEK;
          end
        end
        ST_SEEK:
        begin
          if (any_limit)
          begin
            home_jog_ff <= {NAX{1'b0}};
            cnt_ff      <= 32'h00000000;
            st_ff       <= ST_DEB;
          end
        end
        ST_DEB:
        begin
          // A bouncing limit restarts the debounce interval.
          if (!any_limit)
            cnt_ff <= 32'h00000000;
          else if (cnt_ff >= {8'h00, deb_lim_ff})                   // see RULE6 see RULE21
          begin
            cnt_ff <= 32'h00000000;
            if (l2m_en_ff)
            begin
              l2m_move_ff <= 1'b1;
              st_ff       <= ST_L2M;
            end
            else
            begin
              linked_ff   <= 1'b0;
              home_jog_ff <= {NAX{1'b1}};
              mfound_ff   <= {NAX{1'b0}};
              st_ff       <= ST_MARK;
            end
          end
          else
            cnt_ff <= cnt_ff + 32'h00000001;
        end
        ST_L2M:
        begin
          if (&move_done)                                           // see RULE6
          begin
            linked_ff   <= 1'b0;
            home_jog_ff <= {NAX{1'b1}};
            mfound_ff   <= {NAX{1'b0}};
            st_ff       <= ST_MARK;
          end
        end
        ST_MARK:
        begin
          // Follow-type slaves take their master's marker instead of their own.
          for (i = 0; i < NAX; i = i + 1)
            if (!mfound_ff[i] && (fol[i] ? marker_hit[mst[i*2 +: 2]] : marker_hit[i]))
            begin
              mfound_ff[i]    <= 1'b1;
              pos_clear_ff[i] <= 1'b1;                              // see RULE4 see RULE7 see RULE20
            end
          if (all_marked)
          begin
            home_jog_ff <= {NAX{1'b0}};                             // see RULE8
            cnt_ff      <= 32'h00000000;
            st_ff       <= ST_DWELL;
          end
        end
        ST_DWELL:
        begin
          if (abort_key || sw_abort)                                // see RULE11
          begin
            mdist_ff  <= axis_position;
            linked_ff <= 1'b1;
            st_ff     <= ST_IDLE;
          end
          else if (cnt_ff >= DWELL_CYC - 1)
          begin
            mdist_ff <= axis_position;                              // see RULE8
            for (i = 0; i < NAX; i = i + 1)
              offset_dist_ff[i*PW +: PW] <=
                ofs_ff[(fol[i] ? mst[i*2 +: 2] : i[1:0])*PW +: PW]
                - axis_position[i*PW +: PW];                        // see RULE9 see RULE20
            offset_move_ff <= {NAX{1'b1}};
            odone_ff       <= {NAX{1'b0}};
            st_ff          <= ST_OFS;
          end
          else
            cnt_ff <= cnt_ff + 32'h00000001;
        end
        ST_OFS:
        begin
          odone_ff <= odone_ff | (move_done & ~offset_move_ff);
          if (all_done)
            st_ff <= ST_ZERO;
        end
        ST_ZERO:
        begin
          pos_clear_ff <= {NAX{1'b1}};                              // see RULE10
          linked_ff    <= 1'b1;
          home_done_ff <= 1'b1;
          st_ff        <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ===================================================================
  // Register reads; unmapped addresses read as zero.
  always @(posedge clk)
  begin
    if (reset)
      reg_rdata_ff <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `GHF_REG_CTRL:      reg_rdata_ff <= {29'h0, l2m_en_ff, 2'h0};
        `GHF_REG_STATUS:    reg_rdata_ff <= {16'h0, odone_ff, mfound_ff,
                                             2'h0, linked_ff, home_done_ff, st_ff};
        `GHF_REG_PFB_CODE:  reg_rdata_ff <= {8'h0, pfb_ff};
        `GHF_REG_SFB_CODE:  reg_rdata_ff <= {12'h0, sfb_ff};
        `GHF_REG_RES_CODE:  reg_rdata_ff <= {4'h0, sres_ff, 4'h0, pres_ff};
        `GHF_REG_DEBOUNCE:  reg_rdata_ff <= {8'h0, deb_lim_ff};
        `GHF_REG_SFB_INFO:  reg_rdata_ff <= {20'h0, lfine, styp};
        `GHF_REG_SLAVE_INFO: reg_rdata_ff <= {16'h0, mst, fol, sep};
        default:
        begin
          if (reg_addr >= `GHF_REG_HOME_OFS0 && reg_addr < `GHF_REG_MARK_DIST0)
            reg_rdata_ff <= ofs_ff[(reg_addr - `GHF_REG_HOME_OFS0) * PW +: PW];
          else if (reg_addr >= `GHF_REG_MARK_DIST0 && reg_addr < `GHF_REG_DEBOUNCE)
            reg_rdata_ff <= mdist_ff[(reg_addr - `GHF_REG_MARK_DIST0) * PW +: PW];
          else
            reg_rdata_ff <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // ghf_gantry_home

`default_nettype wire

// ### src/ghf_regs.vh
`ifndef GHF_REGS_VH
`define GHF_REGS_VH

// =====================================================================
// Register offsets (word index on the plain register port)
`define GHF_REG_CTRL        4'h0
`define GHF_REG_STATUS      4'h1
`define GHF_REG_PFB_CODE    4'h2
`define GHF_REG_SFB_CODE    4'h3
`define GHF_REG_RES_CODE    4'h4
`define GHF_REG_HOME_OFS0   4'h5
`define GHF_REG_MARK_DIST0  4'h9
`define GHF_REG_DEBOUNCE    4'hD
`define GHF_REG_SFB_INFO    4'hE
`define GHF_REG_SLAVE_INFO  4'hF

// =====================================================================
// Control register bits
`define GHF_CTRL_START_BIT  0
`define GHF_CTRL_ABORT_BIT  1
`define GHF_CTRL_L2M_BIT    2

// =====================================================================
// Feedback channel codes
`define GHF_PFB_SLAVE_LO    6'h29
`define GHF_PFB_SLAVE_HI    6'h2C
`define GHF_PFB_FOLLOW_LO   6'h25
`define GHF_PFB_FOLLOW_HI   6'h28
`define GHF_SFB_OPEN        5'h00
`define GHF_SFB_ENC_HI      5'h08
`define GHF_SFB_RES_HI      5'h10
`define GHF_SFB_LASER_FINE  5'h14
`define GHF_SFB_LASER_HI    5'h18

// Secondary feedback source types
`define GHF_SRC_OPEN        2'h0
`define GHF_SRC_ENC         2'h1
`define GHF_SRC_RES         2'h2
`define GHF_SRC_LASER       2'h3

// =====================================================================
// Reset values and the resolver code limit
`define GHF_RES_CODE_RST    3'h3
`define GHF_RES_CODE_MAX    3'h5
`define GHF_DEBOUNCE_RST    24'h0186A0

// =====================================================================
// Timing
`define GHF_CLK_HZ          50000000
`define GHF_DWELL_MS        1000
`define GHF_DWELL_CYC       (`GHF_CLK_HZ / 1000 * `GHF_DWELL_MS)

`endif

// ### src/ghf_axis_cfg.v
`default_nettype none

// =====================================================================
// Per-axis decode of a feedback code and a resolver code.
module ghf_axis_cfg #(
  parameter [1:0] AXIS = 2'h0
) (
  // Codes
  input  wire [5:0] pfb_code,
  input  wire [4:0] sfb_code,
  input  wire [2:0] res_code,
  // Decoded
  output wire       slave_sep,
  output wire       slave_follow,
  output wire [1:0] master_idx,
  output wire [1:0] sfb_type,
  output wire       laser_fine,
  output wire [4:0] res_bits
);

`include "ghf_regs.vh"

  wire in_sep = (pfb_code >= `GHF_PFB_SLAVE_LO) && (pfb_code <= `GHF_PFB_SLAVE_HI);
  wire in_fol = (pfb_code >= `GHF_PFB_FOLLOW_LO) && (pfb_code <= `GHF_PFB_FOLLOW_HI);
  wire [5:0] ofs = in_sep ? (pfb_code - `GHF_PFB_SLAVE_LO) : (pfb_code - `GHF_PFB_FOLLOW_LO);

  assign master_idx   = ofs[1:0];
  // A code naming the axis itself is refused and leaves the axis unlinked.
  assign slave_sep    = in_sep && (ofs[1:0] != AXIS);     // see RULE1 see RULE13
  assign slave_follow = in_fol && (ofs[1:0] != AXIS);     // see RULE20

  assign sfb_type = (sfb_code == `GHF_SFB_OPEN)    ? `GHF_SRC_OPEN :
                    (sfb_code <= `GHF_SFB_ENC_HI)  ? `GHF_SRC_ENC  :
                    (sfb_code <= `GHF_SFB_RES_HI)  ? `GHF_SRC_RES  :
                    `GHF_SRC_LASER;                       // see RULE14
  assign laser_fine = (sfb_code > `GHF_SFB_RES_HI) &&
                      (sfb_code <= `GHF_SFB_LASER_FINE);  // see RULE16

  // Resolution in bits; 0 means not applicable, 16 for dynamic 16/14.
  assign res_bits = (res_code == 3'h1) ? 5'h0A :
                    (res_code == 3'h2) ? 5'h0C :
                    (res_code == 3'h3) ? 5'h0E :
                    (res_code == 3'h4) ? 5'h10 :
                    (res_code == 3'h5) ? 5'h10 : 5'h00;   // see RULE17 see RULE18

endmodule // ghf_axis_cfg

`default_nettype wire

// ### tb/ghf_gantry_home_chk.sv
`default_nettype none
// ====================
// Port checks of the homing sequencer and the axis linking.
module ghf_chk #(
  parameter DWELL_CYC = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register writes
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Host and plant
  input wire logic [3:0]  axis_enable_req,
  input wire logic [3:0]  move_cmd_req,
  input wire logic        abort_key,
  input wire logic [3:0]  limit_hit,
  input wire logic [3:0]  marker_hit,
  // Sequencer outputs
  input wire logic [3:0]  axis_enable,
  input wire logic [3:0]  move_cmd,
  input wire logic [3:0]  home_jog_ff,
  input wire logic [3:0]  pos_clear_ff,
  input wire logic [3:0]  offset_move_ff,
  input wire logic        l2m_move_ff,
  input wire logic        linked_ff,
  input wire logic        home_done_ff,
  input wire logic [7:0]  loop_enc_sel_ff
);
  localparam int DW_MIN = DWELL_CYC - 1;
  logic [23:0] pfb_ff;
  logic [15:0] dw_ff;
  logic [3:0]  exp_en, exp_mv;
  logic [5:0]  c, m;
  logic        s;

  // ====================
  // Shadow of the primary codes and a count of still cycles while unlinked.
  always_ff @(posedge clk)
  begin
    if (reset)
      pfb_ff <= 24'h000000;
    else if (reg_wr && reg_addr == 4'h2)
      pfb_ff <= reg_wdata[23:0];
    if (reset || linked_ff || home_jog_ff != 4'h0)
      dw_ff <= 16'h0000;
    else if (dw_ff != 16'hFFFF)
      dw_ff <= dw_ff + 16'h0001;
  end

  // A code naming the axis itself is no link, so that axis keeps its own request.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      c = pfb_ff[6*i +: 6];
      m = (c >= 6'h29) ? c - 6'h29 : c - 6'h25;
      s = c >= 6'h25 && c <= 6'h2C && m[1:0] != i[1:0];
      exp_en[i] = s ? axis_enable_req[m[1:0]] : axis_enable_req[i];
      exp_mv[i] = s ? move_cmd_req[m[1:0]] : move_cmd_req[i];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ====================
  // Assertions
  enable_follow_a: assert property (axis_enable == exp_en)
    else $error("axis enable differs from linked request");
  move_follow_a: assert property (move_cmd == exp_mv)
    else $error("move command differs from linked request");
  own_loop_a: assert property (loop_enc_sel_ff == 8'hE4)
    else $error("servo loop not on own encoder");
  start_jog_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0]
    && linked_ff && home_jog_ff == 4'h0 && limit_hit == 4'h0 |-> ##2 home_jog_ff == 4'hF)
    else $error("home jog not started");
  limit_stop_a: assert property (linked_ff && home_jog_ff == 4'hF && limit_hit != 4'h0
    |-> ##[1:2] home_jog_ff == 4'h0)
    else $error("jog not stopped at limit");
  marker_clear_a: assert property ($rose(marker_hit[0]) && !linked_ff
    && home_jog_ff[0] |-> ##[0:2] pos_clear_ff[0])
    else $error("position not cleared at marker");
  dwell_len_a: assert property (offset_move_ff != 4'h0 |-> dw_ff >= DW_MIN)
    else $error("offset move before dwell ended");
  offset_all_a: assert property (offset_move_ff != 4'h0 |->
    offset_move_ff == 4'hF && !linked_ff)
    else $error("offset moves not unlinked on all axes");
  done_relink_a: assert property ($rose(home_done_ff) |-> linked_ff
    && (pos_clear_ff == 4'hF || $past(pos_clear_ff) == 4'hF))
    else $error("home done without relink and clear");
  abort_dwell_a: assert property (abort_key && !linked_ff && home_jog_ff == 4'h0
    && dw_ff > 16'h0001 && dw_ff < DW_MIN |-> ##[1:3] linked_ff && !home_done_ff)
    else $error("abort in dwell not honoured");
  l2m_linked_a: assert property (l2m_move_ff |-> linked_ff && home_jog_ff == 4'h0)
    else $error("limit to marker move while unlinked");
endmodule // ghf_chk

bind ghf_gantry_home ghf_chk #(.DWELL_CYC(DWELL_CYC)) i_chk (.*);
`default_nettype wire

// ### tb/ghf_axis_model.sv
`default_nettype none
// ====================
// Four encoder axes with a shared home limit and one marker each.
module ghf_axis_model (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Sequencer commands
  input  wire logic [3:0]   home_jog_ff,
  input  wire logic [3:0]   pos_clear_ff,
  input  wire logic [3:0]   offset_move_ff,
  input  wire logic [127:0] offset_dist_ff,
  input  wire logic         l2m_move_ff,
  input  wire logic         linked_ff,
  // Plant answers
  output logic [3:0]        limit_hit,
  output logic [3:0]        marker_hit,
  output logic [3:0]        move_done,
  output logic [127:0]      axis_position,
  output logic [127:0]      dist_seen,
  output logic [127:0]      cmd_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] jc_ff;
  logic [7:0] mc_ff [4];
  logic [7:0] mv_ff [4];

  // Every axis gets the same home motion, so the limit is met by all at once.
  always_ff @(posedge clk)
  begin
    if (reset || !linked_ff)
      jc_ff <= 8'h00;
    else if (home_jog_ff == 4'hF)
      jc_ff <= jc_ff + 8'h01;
    if (reset || !linked_ff)
      limit_hit <= 4'h0;
    else if (jc_ff >= 8'h08)
      limit_hit <= 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      if (reset || linked_ff)
        mc_ff[i] <= 8'h00;
      else if (home_jog_ff[i])
        mc_ff[i] <= mc_ff[i] + 8'h01;
      // Markers lie at a different spot on each axis, as on a skewed gantry.
      marker_hit[i] <= !reset && !linked_ff && home_jog_ff[i] && mc_ff[i] == 8'(5 + 3 * i);
      if (reset || pos_clear_ff[i])
        axis_position[32*i +: 32] <= 32'h00000000;
      else if (home_jog_ff[i])
        axis_position[32*i +: 32] <= axis_position[32*i +: 32] + 32'h00000001;
      if (reset)
        mv_ff[i] <= 8'h00;
      else if (offset_move_ff[i] || l2m_move_ff)
        mv_ff[i] <= 8'(3 + 2 * i);
      else if (mv_ff[i] != 8'h00)
        mv_ff[i] <= mv_ff[i] - 8'h01;
      move_done[i] <= !reset && !(offset_move_ff[i] || l2m_move_ff)
                      && (move_done[i] || mv_ff[i] == 8'h01);
      if (offset_move_ff[i])
      begin
        dist_seen[32*i +: 32] <= axis_position[32*i +: 32];
        cmd_seen[32*i +: 32] <= offset_dist_ff[32*i +: 32];
      end
    end
  end
endmodule // ghf_axis_model
`default_nettype wire

// ### tb/test_gantry_home_and_feedback_select.sv
`default_nettype none
`include "ghf_regs.vh"
module test_gantry_home_and_feedback_select;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DWELL = 20;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic [3:0]   reg_addr = 4'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [3:0]   axis_enable_req = 4'h0;
  logic [3:0]   move_cmd_req = 4'h0;
  logic         abort_key = 1'b0;
  wire  [31:0]  reg_rdata_ff;
  wire  [3:0]   limit_hit, marker_hit, move_done, axis_enable, move_cmd;
  wire  [3:0]   home_jog_ff, pos_clear_ff, offset_move_ff;
  wire          l2m_move_ff, linked_ff, home_done_ff;
  wire  [7:0]   loop_enc_sel_ff;
  wire  [19:0]  pri_res_bits_ff, sec_res_bits_ff;
  wire  [127:0] axis_position, offset_dist_ff, dist_seen, cmd_seen;
  int           bad_count = 0;
  int           num_checks = 0;
  int           n;
  logic [31:0]  rv, d;
  logic [2:0]   rc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  logic [4:0]   rb [6] = '{5'h00, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h0E};
  logic [31:0]  sc [2] = '{32'h0008A500, 32'h000C1690};
  logic [31:0]  si [2] = '{32'h000008E4, 32'h000002DE};
  logic [3:0]   ev [2] = '{4'h1, 4'h6};
  logic [3:0]   ee [2] = '{4'h3, 4'hC};

  always #10 clk = ~clk;

  ghf_gantry_home #(.DWELL_CYC(DWELL)) i_dut (.*);

  ghf_axis_model i_axes (.*);

  // ====================
  // Register access and comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata_ff;
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return home_done_ff;
      1: return !linked_ff;
      2: return home_jog_ff == 4'hF;
      3: return home_jog_ff == 4'h0;
      default: return |limit_hit;
    endcase
  endfunction

  task automatic wt(input int k);
    for (n = 0; n < 3000 && cond(k) !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    if (n == 3000)
      chk("wait", 32'h1, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ====================
  // Test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(`GHF_REG_RES_CODE);
    chk("res codes", 32'h06DB06DB, rv);
    rd(`GHF_REG_SFB_CODE);
    chk("sfb codes", 32'h00020C41, rv);
    rd(`GHF_REG_DEBOUNCE);
    chk("debounce", 32'h000186A0, rv);
    rd(`GHF_REG_SFB_INFO);
    chk("sfb info", 32'h00000055, rv);
    for (int k = 0; k < 6; k++)
    begin
      d = 32'h0;
      for (int i = 0; i < 4; i++)
      begin
        d[3*i +: 3] = rc[k];
        d[16+3*i +: 3] = rc[k];
      end
      wr(`GHF_REG_RES_CODE, d);
      repeat (2) @(posedge clk);
      #1 chk("pri bits", {12'h0, {4{rb[k]}}}, {12'h0, pri_res_bits_ff});
      chk("sec bits", {12'h0, {4{rb[k]}}}, {12'h0, sec_res_bits_ff});
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(`GHF_REG_SFB_CODE, sc[k]);
      rd(`GHF_REG_SFB_INFO);
      chk("sfb info", si[k], rv);
    end
    wr(`GHF_REG_PFB_CODE, 32'h009ABA40);
    rd(`GHF_REG_SLAVE_INFO);
    chk("slave info", 32'h00004082, rv & 32'h0000CCFF);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      axis_enable_req <= ev[k];
      move_cmd_req <= ev[k];
      @(posedge clk);
      #1 chk("enable", {28'h0, ee[k]}, {28'h0, axis_enable});
      chk("move", {28'h0, ee[k]}, {28'h0, move_cmd});
    end
    wr(`GHF_REG_PFB_CODE, 32'h00000A40);
    wr(`GHF_REG_DEBOUNCE, 32'h00000005);
    for (int i = 0; i < 4; i++)
      wr(4'(`GHF_REG_HOME_OFS0 + i), 32'h100 + i);
    wr(`GHF_REG_CTRL, 32'h00000005);
    wt(4);
    @(posedge clk);
    abort_key <= 1'b1;
    repeat (2) @(posedge clk);
    abort_key <= 1'b0;
    wt(0);
    @(posedge clk);
    #1;
    chk("linked", 32'h1, {31'h0, linked_ff});
    for (int i = 0; i < 4; i++)
    begin
      chk("offset", 32'h100 + i - dist_seen[32*i +: 32], cmd_seen[32*i +: 32]);
      chk("position", 32'h0, axis_position[32*i +: 32]);
      rd(4'(`GHF_REG_MARK_DIST0 + i));
      chk("marker dist", dist_seen[32*i +: 32], rv);
    end
    wr(`GHF_REG_CTRL, 32'h00000001);
    repeat (3) @(posedge clk);
    #1 chk("done cleared", 32'h0, {31'h0, home_done_ff});
    wt(1);
    wt(2);
    wt(3);
    @(posedge clk);
    abort_key <= 1'b1;
    repeat (3) @(posedge clk);
    abort_key <= 1'b0;
    #1 chk("abort relink", 32'h1, {31'h0, linked_ff});
    repeat (DWELL + 20) @(posedge clk);
    #1 chk("abort done", 32'h0, {31'h0, home_done_ff});
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule // test_gantry_home_and_feedback_select
`default_nettype wire
